//--- bench/rx_harness.sv
/*
 * Far-side test harness model: samples the observation bus.
 * Assumes it shares the core clock and reset.
 */
`timescale 1ns/1ns
module rx_harness (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [rx_obs_pkg::OBS_W-1:0] test_out,
    output logic      [7:0]                   seen_chk,
    output logic      [2:0]                   seen_chan
);
    // ==========================================
    // capture on the valid pulse only
    // sample on valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_chk <= 8'h00;
            seen_chan <= 3'h0;
        end else if (test_out[rx_obs_pkg::OBS_VALID]) begin
            seen_chk <= test_out[10:3];
            seen_chan <= test_out[13:11];
        end
    end
endmodule

//--- bench/rx_obs_monitor.sv
/*
 * Assertion checker for the receive observer, bound to its top.
 * Assumes one core clock and the observer's own port names.
 */
`timescale 1ns/1ns
module rx_obs_monitor (
    input wire logic                             clk,
    input wire logic                             rst_n,
    input wire rx_obs_pkg::rx_event_t            rx_event,
    input wire logic [rx_obs_pkg::OBS_W-1:0]     test_out,
    input wire rx_obs_pkg::rx_action_t           rx_action
);
    // ==========================================
    // shorthand
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic fatal;
    logic any_ev;
    // done with any dropping error
    assign fatal = rx_event.done && (rx_event.lcrc_seq_err || rx_event.end_len_err
                   || rx_event.form_err || rx_event.fc_rule_err);
    assign any_ev = rx_event.hdr01_valid || rx_event.hdr23_valid || rx_event.data_valid
                    || rx_event.done;

    // ==========================================
    // properties
    property p_hdr01; rx_event.hdr01_valid |=> test_out[0] && test_out[38]; endproperty
    a_hdr01: assert property (p_hdr01) else $error("header 0-1 flag missing");
    property p_hdr23; rx_event.hdr23_valid |=> test_out[1]; endproperty
    a_hdr23: assert property (p_hdr23) else $error("header 2-3 flag missing");
    property p_data; rx_event.data_valid |=> test_out[2]; endproperty
    a_data: assert property (p_data) else $error("payload flag missing");
    property p_lcrc; rx_event.lcrc_check |=> test_out[3]; endproperty
    a_lcrc: assert property (p_lcrc) else $error("lcrc check flag missing");
    property p_seq; rx_event.done && rx_event.lcrc_seq_err |=> test_out[4]; endproperty
    a_seq: assert property (p_seq) else $error("lcrc error bit missing");
    property p_ecrc; rx_event.done && rx_event.ecrc_err |=> test_out[8]; endproperty
    a_ecrc: assert property (p_ecrc) else $error("ecrc bit missing");
    property p_unsup; rx_event.done && rx_event.unsupported |=> test_out[9]; endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported bit missing");
    property p_cfg; rx_event.done && rx_event.cfg_routed |=> test_out[10]; endproperty
    a_cfg: assert property (p_cfg) else $error("config bit missing");
    property p_drop;
        fatal |=> rx_action.drop && !rx_action.store && !rx_action.credit_update;
    endproperty
    a_drop: assert property (p_drop) else $error("bad packet not dropped");
    property p_route;
        rx_action.store && (|test_out[10:8]) |-> rx_action.credit_update ##1 rx_action.cfg_route;
    endproperty
    a_route: assert property (p_route) else $error("stored packet not routed");
    property p_idle; !any_ev |=> !test_out[38]; endproperty
    a_idle: assert property (p_idle) else $error("valid pulse without event");
    property p_reset;
        @(posedge clk) disable iff (1'b0) !rst_n |-> test_out == '0 && rx_action == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not low in reset");
endmodule

bind tlp_receive_test_observer rx_obs_monitor u_mon (
    .clk       (clk),
    .rst_n     (rst_n),
    .rx_event  (rx_event),
    .test_out  (test_out),
    .rx_action (rx_action)
);

//--- bench/test_tlp_receive_test_observer.sv
/*
 * Self-checking bench for the receive observer.
 * Assumes the package, the observer, the harness and the checker.
 */
`timescale 1ns/1ns
module test_tlp_receive_test_observer;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b1;
    logic                  wr = 1'b0;
    logic                  rd = 1'b0;
    rx_obs_pkg::rx_event_t ev = '0;
    logic [3:0]            tin = 4'h0;
    logic [7:0]            addr = 8'h00;
    logic [31:0]           wdata = 32'h0;
    logic [31:0]           rdata;
    logic [38:0]           tout;
    rx_obs_pkg::rx_action_t act;
    logic                  fcm;
    logic                  dcm;
    logic [7:0]            seen_chk;
    logic [2:0]            seen_ch;
    rx_obs_pkg::rx_state_t st;
    logic [2:0]            exp_ch = 3'h0;
    int                    bad_count = 0;
    int                    compares = 0;
    int                    cyc = 0;

    // ==========================================
    // clock, instances
    always #5 clk = ~clk;
    tlp_receive_test_observer dut (
        .clk(clk), .rst_n(rst_n), .rx_event(ev), .test_in(tin), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .test_out(tout),
        .rx_action(act), .state_obs(st), .force_compliance(fcm), .disable_compliance(dcm)
    );
    rx_harness harness (
        .clk(clk), .rst_n(rst_n), .test_out(tout), .seen_chk(seen_chk), .seen_chan(seen_ch)
    );

    // ==========================================
    // tasks
    task automatic chk(input string what, input logic [38:0] exp, input logic [38:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    // one packet, error bits e at done; x is the expected check byte
    task automatic pkt(input logic [7:0] e, input logic [7:0] x);
        logic [6:0] r;
        logic       drop;
        for (int k = 1; k < 8; k++) r[7-k] = e[k];
        drop = |x[4:1];
        @(posedge clk);
        ev <= {4'b1000, 7'h0, 1'b0, 3'd5};
        @(posedge clk);
        ev <= {4'b0100, 7'h0, 1'b0, 3'd5};
        #1 chk("hdr01", 2'b11, {tout[38], tout[0]});
        chk("state hdr01", rx_obs_pkg::ST_HDR01, st);
        @(posedge clk);
        ev <= {4'b0011, 7'h0, 1'b0, 3'd5};
        #1 chk("hdr23", 1'b1, tout[1]);
        @(posedge clk);
        ev <= {4'b0000, r, 1'b1, 3'd5};
        #1 chk("payload", 2'b11, tout[3:2]);
        @(posedge clk);
        ev <= {4'b0000, 7'h0, 1'b0, 3'd5};
        #1 chk("check", x[7:1], tout[10:4]);
        chk("action", {drop, !drop, !drop}, {act.drop, act.store, act.credit_update});
        chk("channel", exp_ch, tout[13:11]);
        chk("state done", (!drop && |x[7:5]) ? rx_obs_pkg::ST_CFG : rx_obs_pkg::ST_IDLE, st);
        @(posedge clk);
        #1 chk("cfg_route", !drop && |x[7:5], act.cfg_route);
        chk("harness", x[7:1], seen_chk[7:1]);
        chk("harness channel", exp_ch, seen_ch);
    endtask

    // ==========================================
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rreg(rx_obs_pkg::REG_CTRL, 32'h0);
        rreg(rx_obs_pkg::REG_TCMAP, 32'h0);
        rreg(rx_obs_pkg::REG_STATUS, 32'h0);
        rreg(8'hfc, 32'h0);
        rreg(8'h28, 32'h0);
        // each check bit 1-7 alone, then its counter
        for (int i = 1; i < 8; i++) begin
            pkt(8'h01 << i, 8'h01 << i);
            rreg(rx_obs_pkg::REG_CNT0 + 8'(4 * (i - 1)), 32'h1);
        end
        rreg(rx_obs_pkg::REG_STATUS, 32'h0000_0080);
        // channel map for traffic class 5
        wreg(rx_obs_pkg::REG_TCMAP, 32'h0003_0000);
        exp_ch = 3'd6;
        pkt(8'h00, 8'h00);
        // injection from control, then counter clear
        wreg(rx_obs_pkg::REG_CTRL, 32'h0000_0008);
        pkt(8'h00, 8'h08);
        wreg(rx_obs_pkg::REG_CTRL, 32'h0000_0001);
        rreg(rx_obs_pkg::REG_CNT0 + 8'h08, 32'h0);
        // pins: lcrc injection and compliance steering
        @(posedge clk);
        tin <= 4'b0101;
        repeat (3) @(posedge clk);
        pkt(8'h00, 8'h02);
        chk("force", 1'b1, fcm);
        @(posedge clk);
        tin <= 4'b1000;
        repeat (4) @(posedge clk);
        #1 chk("steer", 2'b01, {fcm, dcm});
        wreg(rx_obs_pkg::REG_CTRL, 32'h0000_0100);
        repeat (2) @(posedge clk);
        #1 chk("ctrl force", 1'b1, fcm);
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1 chk("reset", 39'h0, tout);
        chk("reset steer", 2'b00, {fcm, dcm});
        @(posedge clk);
        rst_n <= 1'b1;
        tin <= 4'h0;
        rreg(rx_obs_pkg::REG_CTRL, 32'h0);
        end_of_test();
    end
endmodule

//--- hdl/rx_obs_pkg.sv
/*
 * Shared constants and carriers for the receive-side test observer.
 * Assumes one core clock; the receive layer delivers its event flags on that clock.
 */
package rx_obs_pkg;

    // ==========================================
    // observation bus layout
    localparam int OBS_W      = 39;
    localparam int SEQ_LSB    = 0;
    localparam int CHK_LSB    = 3;
    localparam int CHK_MSB    = 10;
    localparam int VC_LSB     = 11;
    localparam int VC_MSB     = 13;
    localparam int OBS_VALID  = 38;

    // ==========================================
    // check field bit positions
    localparam int CK_LCRC_RUN  = 0;
    localparam int CK_LCRC_ERR  = 1;
    localparam int CK_END_LEN   = 2;
    localparam int CK_FORM      = 3;
    localparam int CK_FC_RULE   = 4;
    localparam int CK_ECRC      = 5;
    localparam int CK_UNSUP     = 6;
    localparam int CK_CFG_ROUTE = 7;
    localparam int N_ERR        = 7;

    // ==========================================
    // register map, byte addresses
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          CNT_W       = 16;
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_TCMAP   = 8'h04;
    localparam logic [7:0]  REG_STATUS  = 8'h08;
    localparam logic [7:0]  REG_CNT0    = 8'h0c;
    localparam logic [7:0]  REG_CNT_END = 8'h24;

    // control register fields
    localparam int CTRL_CLR      = 0;
    localparam int CTRL_INJ_LSB  = 1;
    localparam int CTRL_INJ_MSB  = 7;
    localparam int CTRL_FORCE_CM = 8;
    localparam int CTRL_NO_CM    = 9;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [23:0] TCMAP_RESET = 24'h00_0000;

    // test input pins
    localparam int TIN_W        = 4;
    localparam int TIN_INJ_LCRC = 0;
    localparam int TIN_INJ_ECRC = 1;
    localparam int TIN_FORCE_CM = 2;
    localparam int TIN_NO_CM    = 3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR01,
        ST_HDR23,
        ST_PAYLOAD,
        ST_CFG
    } rx_state_t;

    // events from the receive transaction layer, same clock
    typedef struct packed {
        logic       hdr01_valid;
        logic       hdr23_valid;
        logic       data_valid;
        logic       lcrc_check;
        logic       lcrc_seq_err;
        logic       end_len_err;
        logic       form_err;
        logic       fc_rule_err;
        logic       ecrc_err;
        logic       unsupported;
        logic       cfg_routed;
        logic       done;
        logic [2:0] traffic_class;
    } rx_event_t;

    // what happens to a finished packet
    typedef struct packed {
        logic drop;
        logic store;
        logic cfg_route;
        logic credit_update;
    } rx_action_t;

endpackage

//--- hdl/tlp_receive_test_observer.sv
/*
 * Receive transaction layer observer: drives the receive part of the
 * debug output bus, decides the fate of each finished packet, counts
 * every error kind and lets test logic inject errors or steer compliance.
 * Assumes rx events come from logic on clk; test_in comes from outside.
 */
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns

// How it works
// RQ1: bit 0 marks header words 0-1 valid
// RQ2: bit 1 marks header words 2-3 valid
// RQ3: bit 2 marks payload valid
// RQ4: check byte on bits 10:3, bit0 LCRC checking
// RQ5: check bit 1 LCRC or sequence error
// RQ6: check bit 2 END versus length mismatch
// RQ7: check bit 3 formation rule breach
// RQ8: check bit 4 flow control violation
// RQ9: check bit 5 ECRC error, credits updated
// RQ10: check bit 6 unsupported, credits updated
// RQ11: check bit 7 config routed, credits updated
// RQ12: bits 1-4 drop packet, no credits
// RQ13: bits 5-7 store, config route, update credits
// RQ14: bits 13:11 carry mapped virtual channel
// RQ15: expose state and per-error counters
// RQ16: test input injects errors, steers compliance
// RQ17: observers sample only on bit 38
// RQ18: all outputs clocked, low during reset
module tlp_receive_test_observer (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire rx_obs_pkg::rx_event_t             rx_event,
    input  wire logic [rx_obs_pkg::TIN_W-1:0]      test_in,
    input  wire logic [rx_obs_pkg::ADDR_W-1:0]     addr,
    input  wire logic [rx_obs_pkg::DATA_W-1:0]     wdata,
    input  wire logic                              wr,
    input  wire logic                              rd,
    output logic      [rx_obs_pkg::DATA_W-1:0]     rdata,
    output logic      [rx_obs_pkg::OBS_W-1:0]      test_out,
    output rx_obs_pkg::rx_action_t                 rx_action,
    output rx_obs_pkg::rx_state_t                  state_obs,
    output logic                                   force_compliance,
    output logic                                   disable_compliance
);

    // ==========================================
    // helpers

    // saturating counter step
    // saturation keeps a stuck error from wrapping to a small count
    function automatic logic [rx_obs_pkg::CNT_W-1:0] count_up(
        input logic [rx_obs_pkg::CNT_W-1:0] value,
        input logic                         hit
    );
        logic [rx_obs_pkg::CNT_W-1:0] result;
        result = value;
        if (hit && (value != {rx_obs_pkg::CNT_W{1'b1}})) begin
            result = value + {{(rx_obs_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
        return result;
    endfunction

    // traffic class to channel lookup in the map register
    // class n occupies bits 3n+2:3n, so the index is three times tc
    function automatic logic [2:0] channel_of(
        input logic [23:0] map,
        input logic [2:0]  tc
    );
        logic [2:0] result;
        result = map[{tc, 2'b00} - {2'b00, tc} +: 3];
        return result;
    endfunction

    // ==========================================
    // declarations
    logic [rx_obs_pkg::TIN_W-1:0]  tin_meta;
    logic [rx_obs_pkg::TIN_W-1:0]  tin_sync;
    logic [31:0]                   ctrl;
    logic [23:0]                   tc_map;
    logic [7:0]                    last_check;
    logic [7:0]                    check_now;
    logic [rx_obs_pkg::N_ERR-1:0]  inject;
    logic [rx_obs_pkg::CNT_W-1:0]  err_cnt [rx_obs_pkg::N_ERR];
    logic [2:0]                    channel;
    logic                          drop_now;
    logic                          keep_now;
    logic                          cfg_pending;
    logic                          seq_any;
    logic                          reg_hit;
    logic [2:0]                    cnt_index;
    logic [rx_obs_pkg::DATA_W-1:0] next_rdata;
    rx_obs_pkg::rx_state_t         state;
    rx_obs_pkg::rx_state_t         next_state;

    // ==========================================
    // test input synchroniser, two flops
    // test_in is asynchronous; nothing but tin_sync may read tin_meta
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tin_meta <= '0;
            tin_sync <= '0;
        end else begin
            tin_meta <= test_in;
            tin_sync <= tin_meta;
        end
    end

    // ==========================================
    // error injection and check byte

    // register bits and the lcrc and ecrc pins are or-ed, either source injects
    // RQ16: inject from pins or register
    always_comb begin
        inject = ctrl[rx_obs_pkg::CTRL_INJ_MSB:rx_obs_pkg::CTRL_INJ_LSB];
        inject[rx_obs_pkg::CK_LCRC_ERR-1] = inject[rx_obs_pkg::CK_LCRC_ERR-1]
                                            | tin_sync[rx_obs_pkg::TIN_INJ_LCRC];
        inject[rx_obs_pkg::CK_ECRC-1] = inject[rx_obs_pkg::CK_ECRC-1]
                                        | tin_sync[rx_obs_pkg::TIN_INJ_ECRC];
    end

    // RQ4: assemble check byte, lcrc checking in bit 0
    always_comb begin
        check_now = '0;
        check_now[rx_obs_pkg::CK_LCRC_RUN] = rx_event.lcrc_check;
        // RQ5: lcrc or sequence error
        check_now[rx_obs_pkg::CK_LCRC_ERR] = rx_event.lcrc_seq_err;
        // RQ6: end versus length
        check_now[rx_obs_pkg::CK_END_LEN] = rx_event.end_len_err;
        // RQ7: formation rules
        check_now[rx_obs_pkg::CK_FORM] = rx_event.form_err;
        // RQ8: flow control rules
        check_now[rx_obs_pkg::CK_FC_RULE] = rx_event.fc_rule_err;
        // RQ9: ecrc error
        check_now[rx_obs_pkg::CK_ECRC] = rx_event.ecrc_err;
        // RQ10: unsupported packet
        check_now[rx_obs_pkg::CK_UNSUP] = rx_event.unsupported;
        // RQ11: configuration routed
        check_now[rx_obs_pkg::CK_CFG_ROUTE] = rx_event.cfg_routed;
        // injected errors only land on a finished packet
        // so phase cycles never show a false error
        if (rx_event.done) begin
            check_now[rx_obs_pkg::CK_CFG_ROUTE:rx_obs_pkg::CK_LCRC_ERR] =
                check_now[rx_obs_pkg::CK_CFG_ROUTE:rx_obs_pkg::CK_LCRC_ERR] | inject;
        end
    end

    // RQ12: bits 1-4 mean drop
    assign drop_now = rx_event.done
                    & (|check_now[rx_obs_pkg::CK_FC_RULE:rx_obs_pkg::CK_LCRC_ERR]);
    // a clean packet is kept too: stored and credited
    assign keep_now = rx_event.done & ~drop_now;
    assign channel  = channel_of(tc_map, rx_event.traffic_class);
    // the valid pulse covers every phase, done included
    assign seq_any  = rx_event.hdr01_valid | rx_event.hdr23_valid
                    | rx_event.data_valid | rx_event.done;

    // ==========================================
    // reception state machine
    // payload holds until done; done alone picks idle or config
    always_comb begin
        next_state = state;
        case (state)
            rx_obs_pkg::ST_IDLE: begin
                if (rx_event.hdr01_valid) begin
                    next_state = rx_obs_pkg::ST_HDR01;
                end
            end
            rx_obs_pkg::ST_HDR01: begin
                if (rx_event.hdr23_valid) begin
                    next_state = rx_obs_pkg::ST_HDR23;
                end
            end
            rx_obs_pkg::ST_HDR23: begin
                if (rx_event.data_valid) begin
                    next_state = rx_obs_pkg::ST_PAYLOAD;
                end
            end
            rx_obs_pkg::ST_PAYLOAD: begin
                next_state = rx_obs_pkg::ST_PAYLOAD;
            end
            rx_obs_pkg::ST_CFG: begin
                next_state = rx_obs_pkg::ST_IDLE;
            end
            default: begin
                next_state = rx_obs_pkg::ST_IDLE;
            end
        endcase
        // a finished packet ends any phase
        if (rx_event.done) begin
            next_state = (keep_now && (|check_now[rx_obs_pkg::CK_CFG_ROUTE:rx_obs_pkg::CK_ECRC]))
                       ? rx_obs_pkg::ST_CFG : rx_obs_pkg::ST_IDLE;
        end
    end

    // state_obs mirrors state so observers need no internal probe
    // RQ15: state register, visible on state_obs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= rx_obs_pkg::ST_IDLE;
            state_obs <= rx_obs_pkg::ST_IDLE;
        end else begin
            state     <= next_state;
            state_obs <= next_state;
        end
    end

    // ==========================================
    // observation bus
    // default low each cycle, so every field but the channel field (driven each cycle from traffic_class) is a one-cycle pulse
    // RQ18: clocked, all low in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_out <= '0;
        end else begin
            test_out <= '0;
            // RQ1: header words 0 and 1
            test_out[rx_obs_pkg::SEQ_LSB]     <= rx_event.hdr01_valid;
            // RQ2: header words 2 and 3
            test_out[rx_obs_pkg::SEQ_LSB + 1] <= rx_event.hdr23_valid;
            // RQ3: payload phase
            test_out[rx_obs_pkg::SEQ_LSB + 2] <= rx_event.data_valid;
            // RQ4: check byte field
            test_out[rx_obs_pkg::CHK_MSB:rx_obs_pkg::CHK_LSB] <= check_now;
            // RQ14: mapped channel field
            test_out[rx_obs_pkg::VC_MSB:rx_obs_pkg::VC_LSB] <= channel;
            // RQ17: sample strobe
            test_out[rx_obs_pkg::OBS_VALID] <= seq_any;
        end
    end

    // ==========================================
    // packet disposition
    // config routing waits a cycle so the store always lands first
    // RQ13: store first, config route one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_action   <= '0;
            cfg_pending <= 1'b0;
        end else begin
            // RQ12: dropped packets get no store and no credits
            rx_action.drop          <= drop_now;
            rx_action.store         <= keep_now;
            // RQ9: credits also for ecrc, unsupported, config
            rx_action.credit_update <= keep_now;
            rx_action.cfg_route     <= cfg_pending;
            cfg_pending <= keep_now
                         & (|check_now[rx_obs_pkg::CK_CFG_ROUTE:rx_obs_pkg::CK_ECRC]);
        end
    end

    // ==========================================
    // per-error counters
    // clear wins over a count in the same cycle
    // RQ15: one counter per error kind
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < rx_obs_pkg::N_ERR; i++) begin
                err_cnt[i] <= '0;
            end
        end else if (ctrl[rx_obs_pkg::CTRL_CLR]) begin
            for (int i = 0; i < rx_obs_pkg::N_ERR; i++) begin
                err_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < rx_obs_pkg::N_ERR; i++) begin
                err_cnt[i] <= count_up(err_cnt[i], rx_event.done & check_now[i + 1]);
            end
        end
    end

    // last finished packet's check byte
    // feeds the status register, only a finished packet updates it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_check <= '0;
        end else if (rx_event.done) begin
            last_check <= check_now;
        end
    end

    // ==========================================
    // register port

    // control and channel map writes; clear bit is self clearing
    // a write to control in the clear's cycle sets its own clear bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl   <= rx_obs_pkg::CTRL_RESET;
            tc_map <= rx_obs_pkg::TCMAP_RESET;
        end else begin
            ctrl[rx_obs_pkg::CTRL_CLR] <= 1'b0;
            if (wr && (addr == rx_obs_pkg::REG_CTRL)) begin
                ctrl <= wdata;
            end
            if (wr && (addr == rx_obs_pkg::REG_TCMAP)) begin
                tc_map <= wdata[23:0];
            end
        end
    end

    // either source may steer; both give registered levels
    // RQ16: compliance steering from register or pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_compliance   <= 1'b0;
            disable_compliance <= 1'b0;
        end else begin
            force_compliance   <= ctrl[rx_obs_pkg::CTRL_FORCE_CM]
                                | tin_sync[rx_obs_pkg::TIN_FORCE_CM];
            disable_compliance <= ctrl[rx_obs_pkg::CTRL_NO_CM]
                                | tin_sync[rx_obs_pkg::TIN_NO_CM];
        end
    end

    // read decode; unmapped reads return zero
    // counters sit four bytes apart, the last one ends the window
    assign reg_hit   = (addr >= rx_obs_pkg::REG_CNT0) && (addr <= rx_obs_pkg::REG_CNT_END)
                     && (addr[1:0] == 2'b00);
    assign cnt_index = 3'((addr - rx_obs_pkg::REG_CNT0) >> 2);

    always_comb begin
        next_rdata = '0;
        if (addr == rx_obs_pkg::REG_CTRL) begin
            next_rdata = ctrl;
        end else if (addr == rx_obs_pkg::REG_TCMAP) begin
            next_rdata = {8'h00, tc_map};
        end else if (addr == rx_obs_pkg::REG_STATUS) begin
            next_rdata = {21'h00_0000, state, last_check};
        end else if (reg_hit) begin
            next_rdata = {16'h0000, err_cnt[cnt_index]};
        end
    end

    // read data stands one cycle after the strobe only
    // zero between answers so a missed strobe reads as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? next_rdata : '0;
        end
    end

endmodule
